// ==== tcm_timer_config.sv ====
// timer configuration register with mode decode and timer clock prescaler
// assumes an APB master on the same clock and asynchronous edge and 32 kHz
// pins; the counters themselves live outside and consume the event pulses
`timescale 1ns/1ps

module tcm_timer_config #(
  parameter int unsigned ADDR_W = tcm_pkg::ADDR_W,
  parameter int unsigned DATA_W = tcm_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic edge_pin,
  input wire logic alt_clock_pin,
  output tcm_pkg::tcm_cfg_s timer_two_configuration,
  output tcm_pkg::tcm_mode_s mode,
  output tcm_pkg::tcm_event_s events
);

  // the alternate clock must be sampled at least four times a period
  initial begin
    if (tcm_pkg::ALT_RATIO < tcm_pkg::ALT_MIN_RATIO) begin
      $error("system clock too slow to sample the alternate clock");
    end
  end

  // true when the selected edge function matches a synchronised edge
  function automatic logic edge_hit(
    input tcm_pkg::tcm_fn_e fn,
    input logic rise,
    input logic fall
  );
    logic hit;
    hit = 1'b0;
    unique case (fn)
      tcm_pkg::TCM_FN_NONE: hit = 1'b0;
      tcm_pkg::TCM_FN_RISE: hit = rise;
      tcm_pkg::TCM_FN_FALL: hit = fall;
      tcm_pkg::TCM_FN_BOTH: hit = rise | fall;
    endcase
    return hit;
  endfunction

  // divide mask: ratio minus one for a power-of-two prescale code
  function automatic logic [tcm_pkg::PRESCALE_CNT_W-1:0] prescale_mask(
    input logic [tcm_pkg::PRESCALE_W-1:0] code
  );
    logic [tcm_pkg::PRESCALE_CNT_W-1:0] m;
    m = '0;
    for (int i = 0; i < tcm_pkg::PRESCALE_CNT_W; i++) begin
      if (i < int'(code)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // pin synchronisers
  logic edge_level, edge_rise, edge_fall;
  logic alt_level, alt_rise;

  tcm_pin_sync u_edge_sync (
    .clock(clock),
    .srst(srst),
    .pin(edge_pin),
    .level(edge_level),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  tcm_pin_sync u_alt_sync (
    .clock(clock),
    .srst(srst),
    .pin(alt_clock_pin),
    .level(alt_level),
    .rise(alt_rise),
    .fall()
  );

  // register bus
  tcm_pkg::tcm_cfg_s cfg_q, cfg_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [tcm_pkg::PRESCALE_CNT_W-1:0] pre_cnt_q, pre_cnt_d;

  logic access;
  logic hit_cfg;
  logic hit_stat;

  assign access = psel & penable;
  assign hit_cfg = (paddr == tcm_pkg::CFG_ADDR);
  assign hit_stat = (paddr == tcm_pkg::STAT_ADDR);

  always_comb begin
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    // one wait state: answer in the second access cycle
    pready_d = access & ~pready_q;
    if (access & ~pready_q) begin
      prdata_d = '0;
      pslverr_d = ~(hit_cfg | hit_stat);
      if (!pwrite && hit_cfg) begin
        prdata_d[7:0] = cfg_q;
      end
      if (!pwrite && hit_stat) begin
        prdata_d[0] = edge_level;
        prdata_d[1] = alt_level;
        prdata_d[8 +: tcm_pkg::PRESCALE_CNT_W] = pre_cnt_q;
      end
    end
    if (access && pready_q && pwrite && hit_cfg && pstrb[0]) begin
      cfg_d = tcm_pkg::tcm_cfg_s'(pwdata[7:0]);
    end
    if (!access) begin
      pslverr_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q <= tcm_pkg::tcm_cfg_s'(tcm_pkg::CFG_RESET);
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // mode decode
  tcm_pkg::tcm_mode_s mode_q, mode_d;

  always_comb begin
    mode_d = '0;
    mode_d.split_byte_mode = cfg_q.split_byte_mode_select;
    // secondary half exists only in split mode and is always compare
    mode_d.secondary_enabled = cfg_q.split_byte_mode_select;
    if (cfg_q.counter_or_timer_select) begin
      if (cfg_q.capture_compare_function == tcm_pkg::TCM_FN_NONE) begin
        mode_d.primary_disabled = 1'b1;
      end else begin
        mode_d.primary_counter = 1'b1;
      end
    end else begin
      if (cfg_q.capture_compare_function == tcm_pkg::TCM_FN_NONE) begin
        mode_d.primary_compare = 1'b1;
      end else begin
        mode_d.primary_capture_reload = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= '0;
    end else begin
      mode_q <= mode_d;
    end
  end

  // timer clock source and prescaler
  logic src_tick;
  logic pre_tick;
  logic [tcm_pkg::PRESCALE_CNT_W-1:0] pre_mask;

  // alternate clock gives one tick per sampled rising edge
  assign src_tick = cfg_q.alternate_clock_select ? alt_rise : 1'b1;
  assign pre_mask = prescale_mask(cfg_q.timer_clock_prescale);
  assign pre_tick = src_tick & ((pre_cnt_q & pre_mask) == pre_mask);

  always_comb begin
    pre_cnt_d = pre_cnt_q;
    if (src_tick) begin
      // free running; a new ratio takes hold at the next wrap of its mask
      pre_cnt_d = pre_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pre_cnt_q <= tcm_pkg::PRESCALE_CNT_RESET;
    end else begin
      pre_cnt_q <= pre_cnt_d;
    end
  end

  // event generation
  tcm_pkg::tcm_event_s ev_q, ev_d;
  logic pin_hit;

  assign pin_hit = edge_hit(cfg_q.capture_compare_function,
                            edge_rise, edge_fall);

  always_comb begin
    ev_d = '0;
    // primary covers the full 16 bits, or only the upper byte when split
    if (cfg_q.counter_or_timer_select) begin
      ev_d.primary_count = pin_hit;
    end else begin
      ev_d.primary_count = pre_tick;
      ev_d.primary_capture = pin_hit;
    end
    // secondary ignores function and counter select entirely
    if (cfg_q.split_byte_mode_select) begin
      ev_d.secondary_count = pre_tick;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_two_configuration = cfg_q;
  assign mode = mode_q;
  assign events = ev_q;

endmodule

// ==== tcm_pkg.sv ====
// constants, field layout and carrier types of the timer configuration block
// assumes a single 40 MHz system clock and an APB register bus
package tcm_pkg;

  localparam int unsigned CLOCK_HZ = 40000000;
  localparam int unsigned ALT_CLOCK_HZ = 32768;
  // sampling needs four system clocks per alternate clock period at least
  localparam int unsigned ALT_MIN_RATIO = 4;
  localparam int unsigned ALT_RATIO = CLOCK_HZ / ALT_CLOCK_HZ;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] CFG_INDEX = 12'h00f;
  localparam logic [ADDR_W-1:0] STAT_INDEX = 12'h010;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h03c;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h040;

  localparam logic [7:0] CFG_RESET = 8'h00;

  // field positions inside the configuration byte
  localparam int unsigned CTR_SEL_POS = 0;
  localparam int unsigned FN_LSB = 1;
  localparam int unsigned SPLIT_POS = 3;
  localparam int unsigned PRESCALE_LSB = 4;
  localparam int unsigned ALT_SEL_POS = 7;

  localparam int unsigned PRESCALE_W = 3;
  // widest divide ratio is 128, so seven count bits
  localparam int unsigned PRESCALE_CNT_W = 7;
  localparam logic [PRESCALE_CNT_W-1:0] PRESCALE_CNT_RESET = 7'h00;

  typedef enum logic [1:0] {
    TCM_FN_NONE = 2'b00,
    TCM_FN_RISE = 2'b01,
    TCM_FN_FALL = 2'b10,
    TCM_FN_BOTH = 2'b11
  } tcm_fn_e;

  typedef struct packed {
    logic alternate_clock_select;
    logic [PRESCALE_W-1:0] timer_clock_prescale;
    logic split_byte_mode_select;
    tcm_fn_e capture_compare_function;
    logic counter_or_timer_select;
  } tcm_cfg_s;

  // decoded operating mode handed to the counter datapath
  typedef struct packed {
    logic primary_counter;
    logic primary_compare;
    logic primary_capture_reload;
    logic primary_disabled;
    logic secondary_enabled;
    logic split_byte_mode;
  } tcm_mode_s;

  // timing events for the primary upper byte and secondary lower byte
  typedef struct packed {
    logic primary_count;
    logic primary_capture;
    logic secondary_count;
  } tcm_event_s;

endpackage

// ==== tcm_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module tcm_pin_sync (
  input wire logic clock,
  input wire logic srst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;
  logic level_q, level_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  always_comb begin
    s1_d = pin;
    s2_d = s1_q;
    s3_d = s2_q;
    level_d = level_q;
    // a change counts only once the last two stages agree
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
    rise_d = level_d & ~level_q;
    fall_d = ~level_d & level_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      level_q <= level_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule

// ==== tcm_timer_config_assertions.sv ====
// port assertions for the timer configuration block
// assumes it is bound into tcm_timer_config on the system clock
`timescale 1ns/1ps
module tcm_timer_config_assertions #(
  parameter int unsigned ADDR_W = tcm_pkg::ADDR_W,
  parameter int unsigned DATA_W = tcm_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire tcm_pkg::tcm_cfg_s timer_two_configuration,
  input wire tcm_pkg::tcm_mode_s mode,
  input wire tcm_pkg::tcm_event_s events
);
  wire logic [7:0] cf = timer_two_configuration;
  wire logic acc = psel && penable && pready;
  wire logic ctr = cf[0];
  wire logic edge_fn = |cf[2:1];
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_reset_clears: assert property (
    $fell(srst) |-> cf == 8'h00 && mode == 6'h00)
    else $error("outputs not cleared by reset");
  a_write_lands: assert property (
    acc && pwrite && paddr == tcm_pkg::CFG_ADDR && pstrb[0]
    |=> cf == $past(pwdata[7:0])) else $error("config write lost");
  a_write_blocked: assert property (
    acc && pwrite && !(paddr == tcm_pkg::CFG_ADDR && pstrb[0])
    |=> $stable(cf)) else $error("refused write changed config");
  a_one_wait: assert property (
    psel && $rose(penable) |-> !pready ##1 pready ##1 !pready)
    else $error("bus answer timing off");
  a_unmapped_err: assert property (
    acc && paddr != tcm_pkg::CFG_ADDR && paddr != tcm_pkg::STAT_ADDR
    |-> pslverr) else $error("unmapped access not refused");
  a_compare_mode: assert property (
    !$past(srst) |-> mode.primary_compare == $past(!ctr && !edge_fn))
    else $error("compare decode wrong");
  a_capture_mode: assert property (
    !$past(srst) |-> mode.primary_capture_reload == $past(!ctr && edge_fn))
    else $error("capture decode wrong");
  a_counter_mode: assert property (
    !$past(srst) |-> mode.primary_counter == $past(ctr && edge_fn))
    else $error("counter decode wrong");
  a_split_mode: assert property (
    !$past(srst) |-> mode.split_byte_mode == $past(cf[3])
    && mode.secondary_enabled == $past(cf[3])) else $error("split wrong");
  a_disabled_quiet: assert property (
    (ctr && !edge_fn)[*4] |-> !events.primary_count
    && !events.primary_capture) else $error("disabled counter ticks");
  c_cfg_write: cover property (acc && pwrite && paddr == tcm_pkg::CFG_ADDR);
  c_refused: cover property (pslverr);
  c_split_tick: cover property (events.secondary_count);
endmodule
bind tcm_timer_config tcm_timer_config_assertions #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr),
  .timer_two_configuration(timer_two_configuration), .mode(mode),
  .events(events));

// ==== tcm_pin_model.sv ====
// pin-side model: external edge source and free-running 32 kHz clock
// assumes the bench sets the wanted edge level; pins are asynchronous
`timescale 1ns/1ps
module tcm_pin_model (
  input wire logic want,
  output logic edge_pin,
  output logic alt_clock_pin
);
  // about 1220 system clocks per period, far above the 4x minimum
  initial begin
    alt_clock_pin = 1'b0;
    forever #15258.789 alt_clock_pin = ~alt_clock_pin;
  end
  // odd delay keeps pin changes off the system clock grid
  initial begin
    edge_pin = 1'b0;
    forever @(want) edge_pin <= #9 want;
  end
endmodule

// ==== test_timer_config_modes.sv ====
// self-checking bench for the timer configuration block
// assumes the pin model and the bound checker are compiled alongside
`timescale 1ns/1ps
module test_timer_config_modes;
  logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, want = 1'b0, pready, pslverr, edge_pin, alt_clock_pin;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic err;
  tcm_pkg::tcm_cfg_s cfg;
  tcm_pkg::tcm_mode_s mode;
  tcm_pkg::tcm_event_s events;
  int failures = 0, samples_checked = 0, pc, cc, sc;
  tcm_timer_config i_dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .edge_pin(edge_pin), .alt_clock_pin(alt_clock_pin),
    .timer_two_configuration(cfg), .mode(mode), .events(events));
  tcm_pin_model i_pins (.want(want), .edge_pin(edge_pin),
    .alt_clock_pin(alt_clock_pin));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rst(input int n);
    srst <= 1'b1;
    repeat (n) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung transfer
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] v);
    apb(1'b1, tcm_pkg::CFG_ADDR, {24'h0, v}, 4'hf);
  endtask
  // sets the edge level, then counts event pulses
  task automatic cnt(input int n, input logic lvl);
    pc = 0;
    cc = 0;
    sc = 0;
    want <= lvl;
    repeat (n) begin
      @(posedge clock);
      pc += events.primary_count;
      cc += events.primary_capture;
      sc += events.secondary_count;
    end
  endtask
  task automatic t_regs();
    apb(1'b0, tcm_pkg::CFG_ADDR, 32'h0, 4'hf);
    check(rd, 32'h0);
    wr(8'hff);
    apb(1'b0, tcm_pkg::CFG_ADDR, 32'h0, 4'hf);
    check(rd, 32'hff);
    apb(1'b1, tcm_pkg::CFG_ADDR, 32'h0, 4'h0);
    apb(1'b1, 12'h100, 32'h0, 4'hf);
    check({err, cfg}, 9'h1ff);
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    check({err, rd[30:0]}, {1'b1, 31'h0});
    // status word is read only: write ignored without an error
    apb(1'b1, tcm_pkg::STAT_ADDR, 32'h0, 4'hf);
    check({err, cfg}, 9'h0ff);
    rst(2);
    check(cfg, 32'h0);
  endtask
  task automatic t_modes();
    logic c, f, s;
    for (int i = 0; i < 16; i++) begin
      c = i[0];
      f = |i[2:1];
      s = i[3];
      wr(i[7:0]);
      apb(1'b0, tcm_pkg::CFG_ADDR, 32'h0, 4'hf);
      check(rd, {28'h0, i[3:0]});
      check(mode, {c & f, !c & !f, !c & f, c & !f, s, s});
    end
  endtask
  // split follows counter select, so counter runs also cover split
  task automatic t_edges();
    for (int i = 1; i < 8; i++) begin
      if (i[1:0] == 2'b00) continue;
      wr({4'h0, i[2], i[1:0], i[2]});
      repeat (20) @(posedge clock);
      cnt(20, 1'b1);
      check(i[2] ? pc : cc, i[0]);
      check(sc, i[2] ? 20 : 0);
      apb(1'b0, tcm_pkg::STAT_ADDR, 32'h0, 4'hf);
      check(rd[0], 1'b1);
      cnt(20, 1'b0);
      check(i[2] ? pc : cc, i[1]);
      check(sc, i[2] ? 20 : 0);
    end
  endtask
  task automatic t_div();
    for (int k = 0; k < 8; k++) begin
      wr({1'b0, k[2:0], 4'h8});
      repeat (200) @(posedge clock);
      cnt(256, 1'b0);
      check(pc, 256 >> k);
      check(sc, 256 >> k);
    end
  endtask
  task automatic t_alt();
    wr(8'h80);
    repeat (200) @(posedge clock);
    cnt(4883, 1'b0);
    check(pc >= 3 && pc <= 5, 1);
  endtask
  initial begin
    rst(16);
    t_regs();
    t_modes();
    t_edges();
    t_div();
    t_alt();
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    end_of_test();
  end
endmodule
